// ===== hw/segment_latch_consts.vh
// Constants for the segment latch loader
`ifndef SEGMENT_LATCH_CONSTS_VH
`define SEGMENT_LATCH_CONSTS_VH

// Operation codes from the core
`define OP_DECODED       3'h0
`define OP_BLANKING      3'h1
`define OP_RAW_PATTERN   3'h2
`define OP_TABLE_ROM     3'h3
`define OP_SET_FLAG2     3'h4
`define OP_RESET_FLAG2   3'h5

// Flag operand that controls the display
`define FLAG_DISPLAY     4'h4

// Working register base in data memory
`define WORK_REG_BASE    7'h70

// Segment pin kinds
`define SEG_KIND_LCD     2'h0
`define SEG_KIND_CMOS    2'h1
`define SEG_KIND_OPEN    2'h2

// Reset values
`define LATCH_RESET      1'b0
`define DISPLAY_OFF_RST  1'b0

`endif

// ===== hw/digit_decoder.v
// Digit to seven-segment pattern decoder with optional blanking
module digit_decoder #(
    parameter SEVEN_HAS_F = 1
) (
    // Decoder input
    input  wire [3:0] digit,
    input  wire       blank_zero,
    // Bus lines a..h in bits 0..7
    output reg  [7:0] pattern
);

    //------------------------------------------------------------
    // Pattern table
    //------------------------------------------------------------
    always @* begin
        case (digit)
            4'h0: pattern = blank_zero ? 8'h00 : 8'hBF;
            4'h1: pattern = 8'h86;
            4'h2: pattern = 8'hDB;
            4'h3: pattern = 8'hCF;
            4'h4: pattern = 8'hE6;
            4'h5: pattern = 8'hED;
            4'h6: pattern = 8'hFD;
            4'h7: pattern = SEVEN_HAS_F ? 8'hA7 : 8'h87;
            4'h8: pattern = 8'hFF;
            4'h9: pattern = 8'hEF;
            default: pattern = 8'h00;
        endcase
    end

endmodule

// ===== hw/segment_latch_loader.v
// Segment latch array loader and segment pin driver
`include "segment_latch_consts.vh"

// Notes on behaviour
// - Decoded load writes decoded register nibble into addressed latch group.
// - Blanking load outputs all zero bus lines when decoder input is zero.
// - Table load puts ROM word bits 0-7 on lines a-h, undecoded.
// - Raw load: register bits on lines a-d, accumulator on e-h.
// - Decoded and blanking loads also take data from index-pointed memory.
// - Raw load also takes low nibble from index-pointed memory.
// - Set flag with operand 4h blanks the commons and LCD segment outputs, not static pins.
// - Reset flag with operand 4h shows current latch contents again.
// - Each segment has four latches; LCD pin output follows the active common phase, static pins use latch 0.
// - Each latch's data line and strobe are fixed by build parameters.
// - Build config marks pins LCD, CMOS static or open-drain static.
// - Working register operand addresses data memory at operand plus 70H.
// - Four-bit latch address pulses the matching one of sixteen strobes.
// - Decoder maps 0-9 to digit patterns, A-F to zero; digit 7 f optional.
// - Display off keeps latches; loads still update and show later.
// - Stop mode grounds common and LCD segment outputs, not static pins.
module segment_latch_loader #(
    parameter SEG_COUNT   = 9,
    parameter SEVEN_HAS_F = 1,
    // 3-bit bus line select per latch, latch index = seg*4+phase
    parameter [SEG_COUNT*4*3-1:0] BUS_MAP = {SEG_COUNT{12'hFAC}},
    // 4-bit strobe select per latch
    parameter [SEG_COUNT*4*4-1:0] STB_MAP = {SEG_COUNT{16'h3210}},
    // 2-bit pin kind per segment
    parameter [SEG_COUNT*2-1:0]   SEG_KIND = {SEG_COUNT{2'h0}}
) (
    // Clock and reset
    input  wire                 ref_clk,
    input  wire                 rst_n,
    // Instruction from the core
    input  wire                 op_valid,
    input  wire [2:0]           op_code,
    input  wire                 op_indexed,
    input  wire [3:0]           latch_group_addr,
    input  wire [3:0]           work_reg_operand,
    input  wire [3:0]           flag_operand,
    input  wire [6:0]           index_pointer,
    input  wire [3:0]           accumulator_reg,
    output reg                  busy,
    // Data memory and table ROM read port
    output reg                  mem_rd_en,
    output reg  [6:0]           mem_rd_addr,
    input  wire [3:0]           mem_rd_data,
    output reg                  rom_rd_en,
    output reg  [6:0]           rom_rd_addr,
    input  wire [7:0]           table_rom_word,
    // Display timing
    input  wire [1:0]           common_phase,
    input  wire                 stop_mode,
    // Driver side
    output reg  [15:0]          latch_strobe_line,
    output reg                  display_on,
    output reg                  common_enable,
    output reg  [SEG_COUNT-1:0] segment_pin,
    output reg  [SEG_COUNT-1:0] segment_pin_oe
);

    localparam ST_IDLE  = 1'b0;
    localparam ST_FETCH = 1'b1;
    localparam NLATCH   = SEG_COUNT * 4;

    reg              state;
    reg [2:0]        cur_op;
    reg [3:0]        cur_group;
    reg              display_off;
    reg [NLATCH-1:0] latch;

    wire [7:0] decoded;
    reg  [7:0] seg_bus;
    reg  [15:0] next_strobe;

    //------------------------------------------------------------
    // Digit decoder
    //------------------------------------------------------------
    digit_decoder #(
        .SEVEN_HAS_F (SEVEN_HAS_F)
    ) u_decoder (
        .digit       (mem_rd_data),
        .blank_zero  (cur_op == `OP_BLANKING),
        .pattern     (decoded)
    );

    //------------------------------------------------------------
    // Segment bus source and strobe decode
    //------------------------------------------------------------
    always @* begin
        case (cur_op)
            `OP_DECODED:     seg_bus = decoded;
            `OP_BLANKING:    seg_bus = decoded;
            `OP_RAW_PATTERN: seg_bus = {accumulator_reg, mem_rd_data};
            `OP_TABLE_ROM:   seg_bus = table_rom_word;
            default:         seg_bus = 8'h00;
        endcase
        next_strobe = 16'h0000;
        if (state == ST_FETCH)
            next_strobe[cur_group] = 1'b1;
    end

    //------------------------------------------------------------
    // Instruction sequencing
    //------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state             <= ST_IDLE;
            cur_op            <= `OP_DECODED;
            cur_group         <= 4'h0;
            busy              <= 1'b0;
            mem_rd_en         <= 1'b0;
            mem_rd_addr       <= 7'h00;
            rom_rd_en         <= 1'b0;
            rom_rd_addr       <= 7'h00;
            display_off       <= `DISPLAY_OFF_RST;
            latch_strobe_line <= 16'h0000;
        end else begin
            latch_strobe_line <= next_strobe;
            mem_rd_en         <= 1'b0;
            rom_rd_en         <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (op_valid) begin
                        case (op_code)
                            `OP_SET_FLAG2: begin
                                if (flag_operand == `FLAG_DISPLAY)
                                    display_off <= 1'b1;
                            end
                            `OP_RESET_FLAG2: begin
                                if (flag_operand == `FLAG_DISPLAY)
                                    display_off <= 1'b0;
                            end
                            `OP_TABLE_ROM: begin
                                state       <= ST_FETCH;
                                busy        <= 1'b1;
                                cur_op      <= op_code;
                                cur_group   <= latch_group_addr;
                                rom_rd_en   <= 1'b1;
                                rom_rd_addr <= index_pointer;
                            end
                            `OP_DECODED, `OP_BLANKING, `OP_RAW_PATTERN: begin
                                state     <= ST_FETCH;
                                busy      <= 1'b1;
                                cur_op    <= op_code;
                                cur_group <= latch_group_addr;
                                mem_rd_en <= 1'b1;
                                if (op_indexed)
                                    mem_rd_addr <= index_pointer;
                                else
                                    mem_rd_addr <= `WORK_REG_BASE + {3'h0, work_reg_operand};
                            end
                            default: begin
                                state <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_FETCH: begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
                default: begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // Latch array with build-time routing
    //------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NLATCH; gi = gi + 1) begin : g_latch
            wire [2:0] bus_sel = BUS_MAP[gi*3 +: 3];
            wire [3:0] stb_sel = STB_MAP[gi*4 +: 4];
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n)
                    latch[gi] <= `LATCH_RESET;
                else if (state == ST_FETCH && cur_group == stb_sel)
                    latch[gi] <= seg_bus[bus_sel];
            end
        end
    endgenerate

    //------------------------------------------------------------
    // Segment pin drive
    //------------------------------------------------------------
    wire show = ~display_off & ~stop_mode;

    generate
        for (gi = 0; gi < SEG_COUNT; gi = gi + 1) begin : g_pin
            wire [1:0] kind = SEG_KIND[gi*2 +: 2];
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    segment_pin[gi]    <= 1'b0;
                    segment_pin_oe[gi] <= 1'b1;
                end else if (kind == `SEG_KIND_CMOS) begin
                    segment_pin[gi]    <= latch[gi*4];
                    segment_pin_oe[gi] <= 1'b1;
                end else if (kind == `SEG_KIND_OPEN) begin
                    segment_pin[gi]    <= 1'b1;
                    segment_pin_oe[gi] <= latch[gi*4];
                end else begin
                    segment_pin[gi]    <= show & latch[gi*4 + common_phase];
                    segment_pin_oe[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            display_on    <= 1'b0;
            common_enable <= 1'b0;
        end else begin
            display_on    <= ~display_off;
            common_enable <= show;
        end
    end

endmodule

// ===== verification/seg_loader_asserts.sv
// Port checker for the segment latch loader
module seg_loader_asserts (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        op_valid,
    input wire logic [2:0]  op_code,
    input wire logic        op_indexed,
    input wire logic [3:0]  latch_group_addr,
    input wire logic [3:0]  work_reg_operand,
    input wire logic [3:0]  flag_operand,
    input wire logic [6:0]  index_pointer,
    input wire logic        stop_mode,
    input wire logic        busy,
    input wire logic        mem_rd_en,
    input wire logic [6:0]  mem_rd_addr,
    input wire logic        rom_rd_en,
    input wire logic [6:0]  rom_rd_addr,
    input wire logic [15:0] latch_strobe_line,
    input wire logic        display_on,
    input wire logic        common_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    wire take = op_valid && !busy;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence load_taken;
        take && op_code <= 3'h3;
    endsequence
    sequence strobe_for_addr;
        busy ##1 latch_strobe_line == 16'h1 << $past(latch_group_addr, 2);
    endsequence
    a_strobe_addr: assert property (load_taken |=> strobe_for_addr)
        else $error("strobe does not match address");
    a_strobe_single: assert property ($onehot0(latch_strobe_line))
        else $error("several strobes at once");
    a_table_addr: assert property (take && op_code == 3'h3 |=> rom_rd_en && rom_rd_addr == $past(index_pointer))
        else $error("table address wrong");
    a_wreg_addr: assert property (take && op_code < 3'h3 && !op_indexed
        |=> mem_rd_en && mem_rd_addr == {3'h7, $past(work_reg_operand)}) else $error("register address wrong");
    a_index_addr: assert property (take && op_code < 3'h3 && op_indexed
        |=> mem_rd_en && mem_rd_addr == $past(index_pointer)) else $error("index address wrong");
    a_display_off: assert property (take && op_code == 3'h4 && flag_operand == 4'h4 |=> ##1 !display_on)
        else $error("display not off");
    a_display_on: assert property (take && op_code == 3'h5 && flag_operand == 4'h4 |=> ##1 display_on)
        else $error("display not on");
    a_stop_commons: assert property (stop_mode [*2] |-> !common_enable)
        else $error("commons driven in stop");
endmodule

bind segment_latch_loader seg_loader_asserts chk (.ref_clk, .rst_n, .op_valid, .op_code, .op_indexed,
    .latch_group_addr, .work_reg_operand, .flag_operand, .index_pointer, .stop_mode, .busy, .mem_rd_en,
    .mem_rd_addr, .rom_rd_en, .rom_rd_addr, .latch_strobe_line, .display_on, .common_enable);

// ===== verification/core_mem_model.sv
// Core-side model of data memory and table ROM reads
module core_mem_model (
    input wire logic [6:0] mem_rd_addr,
    input wire logic       mem_rd_en,
    input wire logic [6:0] rom_rd_addr,
    input wire logic       rom_rd_en,
    output logic     [3:0] mem_rd_data,
    output logic     [7:0] table_rom_word
);
    timeunit 1ns;
    timeprecision 1ns;
    // Nibble is the low address nibble; released lines show the inverse
    assign mem_rd_data = mem_rd_en ? mem_rd_addr[3:0] : ~mem_rd_addr[3:0];
    assign table_rom_word = {rom_rd_addr[3:0], rom_rd_addr[6:3]} ^ {8{!rom_rd_en}};
endmodule

// ===== verification/segment_latch_loader_test.sv
// Self-checking bench for the segment latch loader
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module segment_latch_loader_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 0, rst_n = 0, op_valid = 0, op_indexed = 0, stop_mode = 0, on_exp = 1;
    logic [2:0]  op_code = 0;
    logic [3:0]  latch_group_addr = 0, work_reg_operand = 0, flag_operand = 0, accumulator_reg = 0, mem_rd_data;
    logic [6:0]  index_pointer = 0, mem_rd_addr, rom_rd_addr;
    logic [1:0]  common_phase = 0;
    logic [7:0]  table_rom_word, lat [4] = '{default: 8'h00};
    logic        busy, mem_rd_en, rom_rd_en, display_on, common_enable;
    logic [15:0] latch_strobe_line;
    logic [8:0]  segment_pin, segment_pin_oe;
    int          errors = 0, cmp_count = 0;
    logic [7:0]  dec [16] = '{8'hBF, 8'h86, 8'hDB, 8'hCF, 8'hE6, 8'hED, 8'hFD, 8'hA7, 8'hFF, 8'hEF,
                              8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // Segment s on line s (seg 8 on line 0), strobe = phase; seg 7 CMOS, seg 8 open-drain
    segment_latch_loader #(.SEG_KIND(18'h24000), .BUS_MAP(108'h000FFFDB6B6D9246DB492249000)) DUT (
        .ref_clk, .rst_n, .op_valid, .op_code, .op_indexed, .latch_group_addr, .work_reg_operand, .flag_operand,
        .index_pointer, .accumulator_reg, .busy, .mem_rd_en, .mem_rd_addr, .mem_rd_data, .rom_rd_en, .rom_rd_addr,
        .table_rom_word, .common_phase, .stop_mode, .latch_strobe_line, .display_on, .common_enable,
        .segment_pin, .segment_pin_oe);
    core_mem_model core (.mem_rd_addr, .mem_rd_en, .rom_rd_addr, .rom_rd_en, .mem_rd_data, .table_rom_word);
    always #50 ref_clk = ~ref_clk;
    // ----------------------------------------
    // Bus tasks and scenarios
    // ----------------------------------------
    task automatic pins();
        for (int ph = 0; ph < 4; ph++) begin
            @(posedge ref_clk);
            common_phase <= 2'(ph);
            repeat (2) @(posedge ref_clk);
            #1 `CHK("lcd pins", on_exp ? lat[ph][6:0] : 7'h00, segment_pin[6:0])
            `CHK("static pins", {1'b1, lat[0][7], lat[0][0]}, {segment_pin[8:7], segment_pin_oe[8]})
            `CHK("pin enables", 8'hFF, segment_pin_oe[7:0])
        end
    endtask
    task automatic issue(input [2:0] op, input ix, input [3:0] lz, input [3:0] v, input [3:0] ac);
        @(posedge ref_clk);
        op_valid <= 1;
        op_code <= op;
        op_indexed <= ix;
        latch_group_addr <= lz;
        work_reg_operand <= v;
        flag_operand <= v;
        index_pointer <= {v[2:0], v};
        accumulator_reg <= ac;
        @(posedge ref_clk);
        op_valid <= 0;
        @(posedge ref_clk);
    endtask
    task automatic load(input [2:0] op, input ix, input [3:0] lz, input [3:0] v, input [3:0] ac);
        logic [7:0] p;
        p = op == 3'h2 ? {ac, v} : op == 3'h3 ? {v, v[2:0], v[3]} : op == 3'h1 && v == 0 ? 8'h00 : dec[v];
        issue(op, ix, lz, v, ac);
        #1 `CHK("strobe", 16'h1 << lz, latch_strobe_line)
        if (lz < 4)
            lat[lz] = p;
        pins();
    endtask
    task automatic t_decode();
        for (int d = 0; d < 16; d++) load(3'h0, 1, 4'(d % 4), 4'(d), 4'h0);
        for (int r = 0; r < 8; r++) load(3'h0, 0, 4'(3 - r % 4), 4'(r), 4'h0);
        $display("Test decode done");
    endtask
    task automatic t_blank_raw();
        load(3'h1, 0, 4'h0, 4'h0, 4'h0);
        load(3'h1, 1, 4'h1, 4'h0, 4'h0);
        load(3'h1, 1, 4'h2, 4'h5, 4'h0);
        load(3'h2, 0, 4'h0, 4'h0, 4'h0);
        load(3'h2, 0, 4'h3, 4'h3, 4'hA);
        load(3'h2, 1, 4'h0, 4'h6, 4'h9);
        load(3'h3, 0, 4'h1, 4'h0, 4'h0);
        load(3'h3, 0, 4'h2, 4'hB, 4'h0);
        for (int z = 4; z < 16; z++) load(3'h0, 0, 4'(z), 4'(z % 8), 4'h0);
        $display("Test blank, raw, table and strobes done");
    endtask
    task automatic t_display();
        issue(3'h4, 0, 4'h0, 4'h3, 4'h0);
        #1 `CHK("display ignored", 1'b1, display_on)
        issue(3'h4, 0, 4'h0, 4'h4, 4'h0);
        #1 `CHK("display off", 2'b00, {display_on, common_enable})
        on_exp = 0;
        load(3'h0, 0, 4'h0, 4'h8, 4'h0);
        issue(3'h5, 0, 4'h0, 4'h4, 4'h0);
        #1 `CHK("display on", 2'b11, {display_on, common_enable})
        on_exp = 1;
        pins();
        @(posedge ref_clk);
        stop_mode <= 1;
        on_exp = 0;
        pins();
        `CHK("stop commons", 1'b0, common_enable)
        @(posedge ref_clk);
        stop_mode <= 0;
        on_exp = 1;
        pins();
        $display("Test display and stop done");
    endtask
    task automatic test_done();
        $display("Compared %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1;
        t_decode();
        t_blank_raw();
        t_display();
        test_done();
    end
    initial begin
        #400000;
        errors++;
        test_done();
    end
endmodule
